// *** pkg/serial_rx_pkg.sv ***
package serial_rx_pkg;

    // Clock and line timing
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_DEFAULT = 9600;
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] MID_TICK = 4'h7;
    localparam logic [3:0] LAST_TICK = 4'hf;
    localparam int DIV_W = 16;
    localparam logic [DIV_W-1:0] DIVISOR_RESET = DIV_W'(CLK_HZ / (BAUD_DEFAULT * OVERSAMPLE) - 1);

    // Register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] RX_STATUS_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] RX_BUF_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] LINE_CFG_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] DIVISOR_OFS = 8'h14;
    localparam int DATA_W = 16;

    // receiver_control_status fields
    localparam int DONE_BIT = 7;
    localparam int SEC_SEND_BIT = 3;
    localparam int RTS_BIT = 2;
    localparam int DTR_BIT = 1;
    localparam int TAPE_EN_BIT = 0;

    // receiver_char_buffer fields
    localparam int ERR_BIT = 15;
    localparam int OVR_BIT = 14;
    localparam int FRM_BIT = 13;
    localparam int PAR_BIT = 12;
    localparam int CHAR_W = 8;

    // Line configuration fields
    localparam int PAR_EN_BIT = 0;
    localparam int PAR_ODD_BIT = 1;

    // Interrupt status / mask fields
    localparam int IRQ_W = 2;
    localparam int IRQ_CHAR_BIT = 0;
    localparam int IRQ_START_BIT = 1;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PARITY = 3'b011,
        RX_STOP = 3'b100
    } rx_state_e;

    typedef struct packed {
        logic parity_en;
        logic parity_odd;
    } line_cfg_s;

    typedef struct packed {
        logic start_mid;
        logic char_done;
        logic stop_bit_error_flag;
        logic parity_error;
        logic [CHAR_W-1:0] data;
    } rx_event_s;

endpackage

// *** rtl/rx_char_deserializer.sv ***
`timescale 1ns/10ps
module rx_char_deserializer (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Line side, already synchronised
    input wire logic tick_i,
    input wire logic line_i,
    input serial_rx_pkg::line_cfg_s cfg_i,
    // Character events
    output serial_rx_pkg::rx_event_s evt_o
);
    import serial_rx_pkg::*;

    typedef struct packed {
        rx_state_e state;
        logic [3:0] phase;
        logic [2:0] bit_cnt;
        logic [CHAR_W-1:0] shift;
        logic par_bit;
        rx_event_s evt;
    } deser_s;

    deser_s st_reg;
    deser_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.evt.start_mid = 1'b0;
        st_next.evt.char_done = 1'b0;
        if (tick_i) begin
            st_next.phase = st_reg.phase + 4'h1;
            case (st_reg.state)
                RX_IDLE: begin
                    st_next.phase = 4'h0;
                    if (!line_i) begin
                        st_next.state = RX_START;
                    end
                end
                RX_START: begin
                    if (st_reg.phase == MID_TICK) begin
                        st_next.phase = 4'h0;
                        st_next.bit_cnt = 3'h0;
                        if (!line_i) begin
                            st_next.state = RX_DATA;
                            st_next.evt.start_mid = 1'b1;
                        end else begin
                            st_next.state = RX_IDLE;
                        end
                    end
                end
                RX_DATA: begin
                    if (st_reg.phase == LAST_TICK) begin
                        st_next.shift = {line_i, st_reg.shift[CHAR_W-1:1]};
                        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                        if (st_reg.bit_cnt == 3'(CHAR_W - 1)) begin
                            st_next.state = cfg_i.parity_en ? RX_PARITY : RX_STOP;
                        end
                    end
                end
                RX_PARITY: begin
                    if (st_reg.phase == LAST_TICK) begin
                        st_next.par_bit = line_i;
                        st_next.state = RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (st_reg.phase == LAST_TICK) begin
                        st_next.state = RX_IDLE;
                        st_next.evt.char_done = 1'b1;
                        st_next.evt.data = st_reg.shift;
                        st_next.evt.stop_bit_error_flag = ~line_i;
                        st_next.evt.parity_error = cfg_i.parity_en &
                            (^st_reg.shift ^ st_reg.par_bit ^ cfg_i.parity_odd);
                    end
                end
                default: begin
                    st_next.state = RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign evt_o = st_reg.evt;

endmodule

// *** rtl/serial_modem_ctl_rx_error_flags.sv ***
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
// Function
// - Set reverse_channel_send bit drives space on the reverse-channel lead; read/write.
// - Request-to-send bit is read/write, drives dataset lead, cleared by bus init.
// - Terminal-ready bit set connects to the dataset channel; clear disconnects.
// - Terminal-ready has no defined value after power-up; reset here loads it with zero.
// - Writing one to tape_advance_enable pulses reader advance and clears char done.
// - tape_advance_enable clears at middle of start bit and on bus init.
// - Summary error flag is OR of overrun, framing and parity flags.
// - Summary error flag never feeds the interrupt logic.
// - Summary error flag is read-only, clears only when its causes clear.
// - Error flags hold until the next character, then update; init may not clear.
// - Overrun sets when a character completes while char done is still set.
// - Char done sets when a complete character is ready for the host.
// - Stop-bit error flag sets when the character lacked a valid stop bit.
// - Parity error sets on parity mismatch; stays zero with parity off.
module serial_modem_ctl_rx_error_flags #(
    parameter logic [serial_rx_pkg::DIV_W-1:0] DIVISOR_DEFAULT = serial_rx_pkg::DIVISOR_RESET
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Bus initialize, same clock domain
    input wire logic bus_init_i,
    // Register port
    input wire logic [serial_rx_pkg::ADDR_W-1:0] addr_i,
    input wire logic [serial_rx_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [serial_rx_pkg::DATA_W-1:0] rdata_o,
    // Serial and modem pins
    input wire logic rx_line_i,
    output logic reverse_channel_send_o,
    output logic request_to_send_o,
    output logic terminal_ready_o,
    output logic tape_advance_o,
    // Interrupt
    output logic irq_o
);
    import serial_rx_pkg::*;

    typedef struct packed {
        logic [1:0] line_sync;
        logic [DIV_W-1:0] div_cnt;
        logic tick;
        logic sec_send;
        logic rts;
        logic dtr;
        logic tape_en;
        logic done;
        logic ovr;
        logic frm;
        logic par;
        logic [CHAR_W-1:0] data;
        line_cfg_s cfg;
        logic [DIV_W-1:0] divisor;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic [DATA_W-1:0] rdata;
    } ctl_state_s;

    localparam ctl_state_s STATE_RESET = '{
        line_sync: 2'h3,
        div_cnt: '0,
        tick: 1'b0,
        sec_send: 1'b0,
        rts: 1'b0,
        dtr: 1'b0,
        tape_en: 1'b0,
        done: 1'b0,
        ovr: 1'b0,
        frm: 1'b0,
        par: 1'b0,
        data: '0,
        cfg: '0,
        divisor: DIVISOR_DEFAULT,
        irq_stat: '0,
        irq_mask: '0,
        irq: 1'b0,
        rdata: '0
    };

    ctl_state_s st_reg;
    ctl_state_s st_next;
    rx_event_s rx_evt;

    rx_char_deserializer u_deser (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .tick_i(st_reg.tick),
        .line_i(st_reg.line_sync[1]),
        .cfg_i(st_reg.cfg),
        .evt_o(rx_evt)
    );

    function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        hit = strobe && (a == ofs);
    endfunction

    function automatic logic [DATA_W-1:0] status_view(input ctl_state_s s);
        status_view = '0;
        status_view[DONE_BIT] = s.done;
        status_view[SEC_SEND_BIT] = s.sec_send;
        status_view[RTS_BIT] = s.rts;
        status_view[DTR_BIT] = s.dtr;
        status_view[TAPE_EN_BIT] = 1'b0;
    endfunction

    function automatic logic [DATA_W-1:0] buffer_view(input ctl_state_s s);
        buffer_view = '0;
        buffer_view[ERR_BIT] = s.ovr | s.frm | s.par;
        buffer_view[OVR_BIT] = s.ovr;
        buffer_view[FRM_BIT] = s.frm;
        buffer_view[PAR_BIT] = s.par;
        buffer_view[CHAR_W-1:0] = s.data;
    endfunction

    always_comb begin
        logic csr_wr;
        logic done_clr;
        logic [IRQ_W-1:0] irq_evt;
        csr_wr = hit(wr_i, addr_i, RX_STATUS_OFS);
        done_clr = 1'b0;
        irq_evt = '0;
        st_next = st_reg;

        // Line synchroniser and oversampling divider
        st_next.line_sync = {st_reg.line_sync[0], rx_line_i};
        st_next.tick = 1'b0;
        if (st_reg.div_cnt >= st_reg.divisor) begin
            st_next.div_cnt = '0;
            st_next.tick = 1'b1;
        end else begin
            st_next.div_cnt = st_reg.div_cnt + DIV_W'(1);
        end

        // Reader advance is held from the enable write until the next start bit is seen
        if (rx_evt.start_mid) begin
            st_next.tape_en = 1'b0;
        end
        if (csr_wr) begin
            st_next.sec_send = wdata_i[SEC_SEND_BIT];
            st_next.rts = wdata_i[RTS_BIT];
            st_next.dtr = wdata_i[DTR_BIT];
            if (wdata_i[TAPE_EN_BIT]) begin
                st_next.tape_en = 1'b1;
                done_clr = 1'b1;
            end
        end
        if (hit(rd_i, addr_i, RX_BUF_OFS)) begin
            done_clr = 1'b1;
        end
        if (bus_init_i) begin
            st_next.sec_send = 1'b0;
            st_next.rts = 1'b0;
            st_next.tape_en = 1'b0;
            done_clr = 1'b1;
        end

        // Character completion: flags captured as one set, kept until the next
        if (rx_evt.char_done) begin
            st_next.data = rx_evt.data;
            st_next.ovr = st_reg.done;
            st_next.frm = rx_evt.stop_bit_error_flag;
            st_next.par = rx_evt.parity_error;
            irq_evt[IRQ_CHAR_BIT] = 1'b1;
        end
        if (rx_evt.start_mid) begin
            irq_evt[IRQ_START_BIT] = 1'b1;
        end
        st_next.done = (st_reg.done & ~done_clr) | rx_evt.char_done;

        // Configuration registers
        if (hit(wr_i, addr_i, LINE_CFG_OFS)) begin
            st_next.cfg.parity_en = wdata_i[PAR_EN_BIT];
            st_next.cfg.parity_odd = wdata_i[PAR_ODD_BIT];
        end
        if (hit(wr_i, addr_i, DIVISOR_OFS)) begin
            st_next.divisor = wdata_i[DIV_W-1:0];
        end

        // Interrupts: only character and start events, never the error summary
        if (hit(wr_i, addr_i, IRQ_MASK_OFS)) begin
            st_next.irq_mask = wdata_i[IRQ_W-1:0];
        end
        st_next.irq_stat = st_reg.irq_stat;
        if (hit(wr_i, addr_i, IRQ_STAT_OFS)) begin
            st_next.irq_stat = st_reg.irq_stat & ~wdata_i[IRQ_W-1:0];
        end
        st_next.irq_stat = st_next.irq_stat | irq_evt;
        st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

        // Read data stands for one cycle only
        st_next.rdata = '0;
        if (rd_i) begin
            case (addr_i)
                RX_STATUS_OFS: st_next.rdata = status_view(st_reg);
                RX_BUF_OFS: st_next.rdata = buffer_view(st_reg);
                IRQ_STAT_OFS: st_next.rdata = DATA_W'(st_reg.irq_stat);
                IRQ_MASK_OFS: st_next.rdata = DATA_W'(st_reg.irq_mask);
                LINE_CFG_OFS: begin
                    st_next.rdata[PAR_EN_BIT] = st_reg.cfg.parity_en;
                    st_next.rdata[PAR_ODD_BIT] = st_reg.cfg.parity_odd;
                end
                DIVISOR_OFS: st_next.rdata = DATA_W'(st_reg.divisor);
                default: st_next.rdata = '0;
            endcase
        end
    end

    // Power-up reset gives terminal-ready a known zero; software must not rely on it
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_o = st_reg.rdata;
    assign reverse_channel_send_o = st_reg.sec_send;
    assign request_to_send_o = st_reg.rts;
    assign terminal_ready_o = st_reg.dtr;
    assign tape_advance_o = st_reg.tape_en;
    assign irq_o = st_reg.irq;

endmodule

// *** dv/serial_modem_ctl_rx_error_flags_props.sv ***
`timescale 1ns/10ps
module serial_modem_ctl_rx_error_flags_props (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Bus side
    input wire logic bus_init_i,
    input wire logic [serial_rx_pkg::ADDR_W-1:0] addr_i,
    input wire logic [serial_rx_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [serial_rx_pkg::DATA_W-1:0] rdata_o,
    // Pins
    input wire logic rx_line_i,
    input wire logic reverse_channel_send_o,
    input wire logic request_to_send_o,
    input wire logic terminal_ready_o,
    input wire logic tape_advance_o,
    input wire logic irq_o
);
    import serial_rx_pkg::*;
    logic csr_wr;
    logic tape_wr;
    assign csr_wr = wr_i && addr_i == RX_STATUS_OFS;
    assign tape_wr = csr_wr && wdata_i[TAPE_EN_BIT];
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    chk_tape_pulse: assert property (tape_wr && !bus_init_i |=> tape_advance_o)
        else $error("tape advance pulse missing");
    chk_tape_cause: assert property ($rose(tape_advance_o) |-> $past(tape_wr))
        else $error("tape advance without write");
    chk_rts_write: assert property (csr_wr && !bus_init_i |=> request_to_send_o == $past(wdata_i[RTS_BIT]))
        else $error("request to send not written");
    chk_sec_write: assert property (csr_wr && !bus_init_i |=>
        reverse_channel_send_o == $past(wdata_i[SEC_SEND_BIT]))
        else $error("reverse channel lead not written");
    chk_dtr_write: assert property (csr_wr |=> terminal_ready_o == $past(wdata_i[DTR_BIT]))
        else $error("terminal ready not written");
    chk_init_clears: assert property (bus_init_i |=>
        !request_to_send_o && !reverse_channel_send_o && !tape_advance_o)
        else $error("bus init left a lead set");
    chk_dtr_hold: assert property (!csr_wr |=> $stable(terminal_ready_o))
        else $error("terminal ready changed without write");
    chk_err_or: assert property (rd_i && addr_i == RX_BUF_OFS |=>
        rdata_o[ERR_BIT] == (|rdata_o[OVR_BIT:PAR_BIT]))
        else $error("summary error flag wrong");
    chk_tape_reads0: assert property (rd_i && addr_i == RX_STATUS_OFS |=> !rdata_o[TAPE_EN_BIT])
        else $error("tape enable read back");
    chk_rdata_idle: assert property (!rd_i |=> rdata_o == '0)
        else $error("read data outside read");
    cover property (tape_advance_o);
    cover property (irq_o);
    cover property (bus_init_i ##1 terminal_ready_o);
endmodule
bind serial_modem_ctl_rx_error_flags serial_modem_ctl_rx_error_flags_props u_props (.clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i), .bus_init_i(bus_init_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .rx_line_i(rx_line_i), .reverse_channel_send_o(reverse_channel_send_o),
    .request_to_send_o(request_to_send_o), .terminal_ready_o(terminal_ready_o),
    .tape_advance_o(tape_advance_o), .irq_o(irq_o));

// *** dv/serial_line_model.sv ***
`timescale 1ns/10ps
module serial_line_model (
    // Clock
    input wire logic clk_sys_i,
    // Line toward the receiver, idle at mark
    output logic line_o
);
    initial line_o = 1'b1;
    task automatic drive_bit(input logic v, input int n);
        line_o <= v;
        repeat (n) @(posedge clk_sys_i);
    endtask
    // One bit is 16 clocks with the divisor at zero
    task automatic send(input logic [7:0] data, input logic par_en, input logic par_bit, input logic stop_ok);
        @(posedge clk_sys_i);
        drive_bit(1'b0, 16);
        for (int i = 0; i < 8; i++) begin
            drive_bit(data[i], 16);
        end
        if (par_en) begin
            drive_bit(par_bit, 16);
        end
        if (stop_ok) begin
            drive_bit(1'b1, 16);
        end else begin
            // Low past the stop sample, then high before any false start mid
            drive_bit(1'b0, 12);
            drive_bit(1'b1, 20);
        end
    endtask
endmodule

// *** dv/serial_modem_ctl_rx_error_flags_test.sv ***
`timescale 1ns/10ps
module serial_modem_ctl_rx_error_flags_test;
    import serial_rx_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic bus_init_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic rx_line_i;
    logic rev_send;
    logic rts;
    logic dtr;
    logic tape_adv;
    logic irq_o;
    logic [DATA_W-1:0] v;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    serial_modem_ctl_rx_error_flags #(.DIVISOR_DEFAULT(16'h0000)) DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .bus_init_i(bus_init_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .rx_line_i(rx_line_i), .reverse_channel_send_o(rev_send), .request_to_send_o(rts),
        .terminal_ready_o(dtr), .tape_advance_o(tape_adv), .irq_o(irq_o));
    serial_line_model u_line (.clk_sys_i(clk_sys_i), .line_o(rx_line_i));
    task automatic finish_test;
        $display("compared %0d, wrong %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic compare(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task automatic reg_read(input logic [ADDR_W-1:0] a);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
        v = rdata_o;
    endtask
    task automatic check_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                             input logic [DATA_W-1:0] m, input string what);
        reg_read(a);
        compare(v & m, exp, what);
    endtask
    task automatic irq_expect(input logic exp, input string what);
        repeat (2) @(negedge clk_sys_i);
        compare({15'h0000, irq_o}, {15'h0000, exp}, what);
    endtask
    task automatic wait_done;
        for (int i = 0; i < 100; i++) begin
            reg_read(RX_STATUS_OFS);
            if (v[DONE_BIT] === 1'b1) break;
        end
    endtask
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 10000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        check_reg(RX_STATUS_OFS, 16'h0000, 16'hfffd, "csr after reset");
        reg_write(8'h20, 16'hffff);
        check_reg(8'h20, 16'h0000, 16'hffff, "unmapped read");
        check_reg(LINE_CFG_OFS, 16'h0000, 16'hffff, "unmapped write ignored");
        reg_write(RX_STATUS_OFS, 16'h000e);
        check_reg(RX_STATUS_OFS, 16'h000e, 16'hffff, "csr set");
        compare({13'h0000, rev_send, rts, dtr}, 16'h0007, "modem leads");
        @(posedge clk_sys_i);
        bus_init_i <= 1'b1;
        @(posedge clk_sys_i);
        bus_init_i <= 1'b0;
        check_reg(RX_STATUS_OFS, 16'h0002, 16'hffff, "after init");
        reg_write(RX_STATUS_OFS, 16'h0000);
        check_reg(RX_STATUS_OFS, 16'h0000, 16'hffff, "terminal ready cleared");
        reg_write(IRQ_MASK_OFS, 16'h0001);
        u_line.send(8'ha5, 1'b0, 1'b0, 1'b1);
        wait_done();
        irq_expect(1'b1, "char interrupt");
        check_reg(IRQ_STAT_OFS, 16'h0003, 16'hffff, "irq status");
        reg_write(IRQ_STAT_OFS, 16'h0003);
        irq_expect(1'b0, "irq cleared");
        check_reg(RX_BUF_OFS, 16'h00a5, 16'hffff, "good char");
        check_reg(RX_STATUS_OFS, 16'h0000, 16'h0080, "done cleared by buffer read");
        u_line.send(8'h3c, 1'b0, 1'b0, 1'b0);
        wait_done();
        reg_write(RX_STATUS_OFS, 16'h0001);
        #1;
        compare({15'h0000, tape_adv}, 16'h0001, "tape advance pulse");
        check_reg(RX_STATUS_OFS, 16'h0000, 16'h0081, "done cleared by tape enable");
        check_reg(RX_BUF_OFS, 16'ha03c, 16'hffff, "stop bit error");
        check_reg(RX_BUF_OFS, 16'ha03c, 16'hffff, "flags held");
        compare({15'h0000, tape_adv}, 16'h0001, "tape advance held");
        u_line.send(8'h11, 1'b0, 1'b0, 1'b1);
        wait_done();
        compare({15'h0000, tape_adv}, 16'h0000, "tape advance ended by start bit");
        u_line.send(8'h22, 1'b0, 1'b0, 1'b1);
        wait_done();
        check_reg(RX_BUF_OFS, 16'hc022, 16'hffff, "overrun");
        reg_write(IRQ_MASK_OFS, 16'h0000);
        reg_write(LINE_CFG_OFS, 16'h0001);
        u_line.send(8'h01, 1'b1, 1'b0, 1'b1);
        wait_done();
        irq_expect(1'b0, "masked char interrupt");
        check_reg(RX_BUF_OFS, 16'h9001, 16'hffff, "parity error");
        reg_write(IRQ_MASK_OFS, 16'h0001);
        irq_expect(1'b1, "unmasked interrupt");
        reg_write(IRQ_STAT_OFS, 16'h0003);
        irq_expect(1'b0, "interrupt cleared");
        reg_write(IRQ_MASK_OFS, 16'hffff);
        irq_expect(1'b0, "error alone no interrupt");
        u_line.send(8'h03, 1'b1, 1'b0, 1'b1);
        wait_done();
        check_reg(RX_BUF_OFS, 16'h0003, 16'hffff, "parity good");
        reg_write(LINE_CFG_OFS, 16'h0003);
        u_line.send(8'h03, 1'b1, 1'b0, 1'b1);
        wait_done();
        check_reg(RX_BUF_OFS, 16'h9003, 16'hffff, "odd parity error");
        finish_test();
    end
endmodule
